/* hw/slice_pkg.sv */
// Package for the address/timer slice: instruction codes, modes, mux selects.
// Assumes a single rising-edge clock domain.
package slice_pkg;
    localparam int DataWidth = 8;
    localparam int ModeWidth = 3;
    // Mode register field positions
    localparam int ModeBit0Pos = 0;
    localparam int ModeBit1Pos = 1;
    localparam int AddrDirPos = 2;
    localparam logic [2:0] ModeResetValue = 3'h0;
    localparam logic [7:0] CounterResetValue = 8'h00;
    localparam logic [7:0] AllOnes = 8'hFF;
    localparam logic [7:0] CountOne = 8'h01;
    // Instruction codes
    localparam logic [3:0] write_mode_cmd = 4'h0;
    localparam logic [3:0] read_mode_cmd = 4'h1;
    localparam logic [3:0] read_word_cmd = 4'h2;
    localparam logic [3:0] read_addr_cmd = 4'h3;
    localparam logic [3:0] reload_both_cmd = 4'h4;
    localparam logic [3:0] load_addr_cmd = 4'h5;
    localparam logic [3:0] load_word_cmd = 4'h6;
    localparam logic [3:0] count_enable_cmd = 4'h7;
    localparam logic [3:0] timer_write_mode_cmd = 4'h8;
    localparam logic [3:0] timer_reload_addr_cmd = 4'h9;
    localparam logic [3:0] timer_read_word_cmd = 4'hA;
    localparam logic [3:0] timer_read_addr_cmd = 4'hB;
    localparam logic [3:0] timer_reload_both_cmd = 4'hC;
    localparam logic [3:0] timer_load_addr_cmd = 4'hD;
    localparam logic [3:0] timer_load_word_cmd = 4'hE;
    localparam logic [3:0] timer_reload_word_cmd = 4'hF;
    // Operating modes
    typedef enum logic [1:0] {
        ModeZero = 2'h0,
        ModeCompare = 2'h1,
        ModeAddrCompare = 2'h2,
        ModeCarryOut = 2'h3
    } op_mode_e;
    // Counter next-value actions
    typedef enum logic [1:0] {
        ActHold = 2'h0,
        ActCount = 2'h1,
        ActLoad = 2'h3,
        ActClear = 2'h2
    } cnt_act_e;
    // Multiplexer selections
    typedef enum logic [1:0] {
        SelHigh = 2'h0,
        SelMode = 2'h1,
        SelWord = 2'h3,
        SelAddr = 2'h2
    } mux_sel_e;
endpackage

/* hw/counter_ctl_if.sv */
// Control bundle between the decoder and one counter/holding-register pair.
// Assumes both ends share mclk.
`timescale 1ns/1ps
interface counter_ctl_if;
    import slice_pkg::*;
    cnt_act_e act;
    logic loadHold;
    logic up;
    logic [7:0] loadData;
    logic [7:0] holdValue;
    logic [7:0] count;
    modport ctl (output act, output loadHold, output up, output loadData,
        input holdValue, input count);
    modport cnt (input act, input loadHold, input up, input loadData,
        output holdValue, output count);
endinterface

/* hw/counter_pair.sv */
// One eight-bit up/down counter with its holding register.
// Assumes carry-in is active low and synchronous to mclk.
`timescale 1ns/1ps
module counter_pair
    import slice_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic rst_n, // Async reset
    input wire logic carryIn_n, // Count permit
    counter_ctl_if.cnt ctl // Control bundle
);
    logic [7:0] count_q;
    logic [7:0] hold_q;
    wire [7:0] stepped = ctl.up ? 8'(count_q + CountOne) : 8'(count_q - CountOne);
    wire logic reloadFromHold = (ctl.act == ActLoad) && !ctl.loadHold;
    logic [7:0] count_d;

    always_comb begin
        case (ctl.act)
            ActCount: count_d = carryIn_n ? count_q : stepped;
            ActLoad: count_d = ctl.loadData;
            ActClear: count_d = CounterResetValue;
            default: count_d = count_q;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= CounterResetValue;
            hold_q <= CounterResetValue;
        end else begin
            count_q <= count_d;
            if (ctl.loadHold) begin
                hold_q <= ctl.loadData;
            end
        end
    end

    assign ctl.count = count_q;
    assign ctl.holdValue = hold_q;

    count_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ctl.act == ActCount && carryIn_n) |=> count_q == $past(count_q))
        else $error("counter moved without carry");
    count_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ctl.act == ActCount && !carryIn_n) |=> count_q == $past(stepped))
        else $error("counter did not step");
    reload_copy_a: assert property (@(posedge mclk) disable iff (!rst_n)
        reloadFromHold |=> count_q == $past(hold_q))
        else $error("reload value lost");
endmodule

/* hw/dma_address_timer_slice.sv */
// Top of the eight-bit DMA address / dual timer slice.
// Assumes a microprogrammed controller drives code, data and carries on mclk.
`timescale 1ns/1ps
module dma_address_timer_slice
    import slice_pkg::*;
(
    input wire logic mclk, // Clock, rising edge
    input wire logic rst_n, // Async reset, active low
    input wire logic [3:0] instruction_code, // Instruction code
    input wire logic instr_disable, // High disables code bits 0-2
    input wire logic data_oe_n, // Data output enable, active low
    input wire logic [7:0] dataIn, // Data lines in
    output logic [7:0] dataOut, // Data lines out
    output logic dataOe, // Data lines drive enable
    input wire logic word_carry_in_n, // Word carry in
    output logic word_carry_out_n, // Word carry out
    input wire logic addr_carry_in_n, // Address carry in
    output logic addr_carry_out_n, // Address carry out
    output logic doneOut, // Done, always low when driven
    output logic doneOe, // Done pull-down enable
    output logic [7:0] mux_output // Multiplexer value
);
    logic [2:0] mode_direction_control_q;
    counter_ctl_if wordCtl();
    counter_ctl_if addrCtl();

    // Effective code: disable forces enable-counters of the selected group
    wire logic timerGroup = instruction_code[3];
    wire logic [3:0] effCode = instr_disable ? count_enable_cmd
        : instruction_code;
    wire logic mode_bit0 = mode_direction_control_q[ModeBit0Pos];
    wire logic mode_bit1 = mode_direction_control_q[ModeBit1Pos];
    wire logic addr_direction_bit = mode_direction_control_q[AddrDirPos];
    op_mode_e opMode;
    assign opMode = op_mode_e'({mode_bit1, mode_bit0});
    wire logic clearMode = (opMode == ModeCompare);
    wire logic wordUp = (opMode == ModeCompare) || (opMode == ModeCarryOut);

    // Word reload action: mode 1 clears instead of copying
    function automatic cnt_act_e reloadAct(input logic clr);
        return clr ? ActClear : ActLoad;
    endfunction

    cnt_act_e wordAct;
    cnt_act_e addrAct;
    mux_sel_e muxSel;
    logic loadMode;
    logic wordLoadReg;
    logic addrLoadReg;
    logic [7:0] wordLoadVal;
    logic [7:0] addrLoadVal;

    always_comb begin
        wordAct = ActHold;
        addrAct = ActHold;
        muxSel = SelHigh;
        loadMode = 1'b0;
        wordLoadReg = 1'b0;
        addrLoadReg = 1'b0;
        wordLoadVal = wordCtl.holdValue;
        addrLoadVal = addrCtl.holdValue;
        case (effCode)
            write_mode_cmd: begin
                loadMode = 1'b1;
            end
            read_mode_cmd: muxSel = SelMode;
            read_word_cmd: muxSel = SelWord;
            read_addr_cmd: muxSel = SelAddr;
            reload_both_cmd, timer_reload_both_cmd: begin
                wordAct = reloadAct(clearMode);
                addrAct = ActLoad;
                muxSel = SelAddr;
            end
            load_addr_cmd: begin
                addrAct = ActLoad;
                addrLoadReg = 1'b1;
                addrLoadVal = dataIn;
                muxSel = SelWord;
            end
            load_word_cmd, timer_load_word_cmd: begin
                wordAct = reloadAct(clearMode);
                wordLoadReg = 1'b1;
                wordLoadVal = dataIn;
                addrAct = effCode[3] ? ActCount : ActHold;
            end
            count_enable_cmd: begin
                wordAct = (opMode == ModeAddrCompare) ? ActHold : ActCount;
                addrAct = ActCount;
                muxSel = timerGroup ? SelWord : SelAddr;
            end
            timer_write_mode_cmd: begin
                loadMode = 1'b1;
                wordAct = ActCount;
                addrAct = ActCount;
                muxSel = SelMode;
            end
            timer_reload_addr_cmd: begin
                addrAct = ActLoad;
                wordAct = ActCount;
                muxSel = SelAddr;
            end
            timer_read_word_cmd, timer_read_addr_cmd: begin
                wordAct = ActCount;
                addrAct = ActCount;
                muxSel = effCode[0] ? SelAddr : SelWord;
            end
            timer_load_addr_cmd: begin
                addrAct = ActLoad;
                addrLoadReg = 1'b1;
                addrLoadVal = dataIn;
                wordAct = ActCount;
                muxSel = SelWord;
            end
            default: begin
                wordAct = reloadAct(clearMode);
                addrAct = ActCount;
                muxSel = SelWord;
            end
        endcase
        // Word counter never counts in address compare mode
        if (opMode == ModeAddrCompare && wordAct == ActCount) begin
            wordAct = ActHold;
        end
    end

    assign wordCtl.act = wordAct;
    assign wordCtl.loadHold = wordLoadReg;
    assign wordCtl.up = wordUp;
    assign wordCtl.loadData = wordLoadVal;
    assign addrCtl.act = addrAct;
    assign addrCtl.loadHold = addrLoadReg;
    assign addrCtl.up = !addr_direction_bit;
    assign addrCtl.loadData = addrLoadVal;

    counter_pair wordPair (
        .mclk(mclk),
        .rst_n(rst_n),
        .carryIn_n(word_carry_in_n),
        .ctl(wordCtl)
    );
    counter_pair addrPair (
        .mclk(mclk),
        .rst_n(rst_n),
        .carryIn_n(addr_carry_in_n),
        .ctl(addrCtl)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_direction_control_q <= ModeResetValue;
        end else if (loadMode) begin
            mode_direction_control_q <= dataIn[2:0];
        end
    end

    // Output multiplexer
    wire logic [7:0] wordCnt = wordCtl.count;
    wire logic [7:0] addrCnt = addrCtl.count;
    assign mux_output = (muxSel == SelMode) ? {5'h1F, mode_direction_control_q}
        : (muxSel == SelWord) ? wordCnt
        : (muxSel == SelAddr) ? addrCnt
        : AllOnes;
    assign dataOut = mux_output;
    assign dataOe = !data_oe_n;

    // Transfer complete
    wire logic wordCarryLow = !word_carry_in_n;
    logic doneHigh;
    always_comb begin
        case (opMode)
            ModeZero: doneHigh = wordCarryLow ? (wordCnt == CountOne)
                : (wordCnt == CounterResetValue);
            ModeCompare: doneHigh = wordCarryLow
                ? (8'(wordCnt + CountOne) == wordCtl.holdValue)
                : (wordCnt == wordCtl.holdValue);
            ModeAddrCompare: doneHigh = (addrCnt == wordCnt);
            default: doneHigh = 1'b0;
        endcase
    end
    assign doneOut = 1'b0;
    assign doneOe = !doneHigh;

    // Carry outputs
    wire logic wordTerm = wordUp ? (wordCnt == AllOnes) : (wordCnt == CounterResetValue);
    wire logic addrTerm = addr_direction_bit ? (addrCnt == CounterResetValue)
        : (addrCnt == AllOnes);
    assign word_carry_out_n = !(wordTerm && wordCarryLow);
    assign addr_carry_out_n = !(addrTerm && !addr_carry_in_n);

    // Checks
    wire logic [4:0] issued = {instr_disable, instruction_code};
    wire logic [7:0] wordReg = wordCtl.holdValue;
    wire logic [7:0] addrReg = addrCtl.holdValue;
    sequence loadWordSeq;
        !instr_disable && instruction_code == load_word_cmd && opMode != ModeCompare;
    endsequence
    // Every stored value kept for one cycle
    sequence allHoldSeq;
        wordCnt == $past(wordCnt) && addrCnt == $past(addrCnt) && wordReg == $past(wordReg)
            && addrReg == $past(addrReg)
            && mode_direction_control_q == $past(mode_direction_control_q);
    endsequence
    // Both counters back from their registers, mode 1 clearing the word side
    sequence reloadBothSeq;
        addrCnt == $past(addrReg)
            && wordCnt == ($past(opMode) == ModeCompare ? CounterResetValue : $past(wordReg));
    endsequence
    write_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!instr_disable && instruction_code == write_mode_cmd)
        |=> mode_direction_control_q == $past(dataIn[2:0]) && wordCnt == $past(wordCnt))
        else $error("mode write wrong");
    read_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!instr_disable && instruction_code == read_mode_cmd)
        |-> mux_output == {5'h1F, mode_direction_control_q} ##1 allHoldSeq)
        else $error("mode read wrong");
    read_word_a: assert property (@(posedge mclk) disable iff (!rst_n)
        issued == {1'b0, read_word_cmd} |-> mux_output == wordCnt ##1 allHoldSeq)
        else $error("word read wrong");
    read_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        issued == {1'b0, read_addr_cmd} |-> mux_output == addrCnt ##1 allHoldSeq)
        else $error("address read wrong");
    load_word_a: assert property (@(posedge mclk) disable iff (!rst_n)
        loadWordSeq |=> wordCnt == $past(dataIn) && addrCnt == $past(addrCnt))
        else $error("word load wrong");
    word_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ((issued == {1'b0, load_word_cmd} || issued == {1'b0, timer_load_word_cmd})
            && opMode == ModeCompare)
        |-> mux_output == AllOnes ##1 wordCnt == CounterResetValue && wordReg == $past(dataIn))
        else $error("mode 1 word load wrong");
    load_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!instr_disable && instruction_code == load_addr_cmd)
        |-> mux_output == wordCnt ##1 addrCnt == $past(dataIn) && addrReg == $past(dataIn))
        else $error("address load wrong");
    enable_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (issued == {1'b0, count_enable_cmd} && !addr_carry_in_n) |-> mux_output == addrCnt
        ##1 addrCnt == ($past(addr_direction_bit) ? 8'($past(addrCnt) - CountOne)
            : 8'($past(addrCnt) + CountOne)))
        else $error("address count wrong");
    word_down_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (issued == {1'b0, count_enable_cmd} && opMode == ModeZero && !word_carry_in_n)
        |=> wordCnt == 8'($past(wordCnt) - CountOne))
        else $error("word count down wrong");
    word_up_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (issued == {1'b0, count_enable_cmd} && !word_carry_in_n
            && (opMode == ModeCompare || opMode == ModeCarryOut))
        |=> wordCnt == 8'($past(wordCnt) + CountOne))
        else $error("word count up wrong");
    mode2_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (opMode == ModeAddrCompare && !loadMode && !wordLoadReg && wordAct == ActHold)
        |=> wordCnt == $past(wordCnt))
        else $error("word counted in mode 2");
    reload_both_a: assert property (@(posedge mclk) disable iff (!rst_n)
        issued == {1'b0, reload_both_cmd} |-> mux_output == addrCnt ##1 reloadBothSeq)
        else $error("counter reload wrong");
    disable_show_a: assert property (@(posedge mclk) disable iff (!rst_n)
        instr_disable |-> mux_output == (timerGroup ? wordCnt : addrCnt))
        else $error("disable output wrong");
    timer_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
        issued == {1'b0, timer_write_mode_cmd} |-> mux_output == {5'h1F, mode_direction_control_q}
        ##1 mode_direction_control_q == $past(dataIn[2:0]))
        else $error("timer mode write wrong");
    reload_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        issued == {1'b0, timer_reload_addr_cmd} |-> mux_output == addrCnt
        ##1 addrCnt == $past(addrReg))
        else $error("address reload wrong");
    timer_word_a: assert property (@(posedge mclk) disable iff (!rst_n)
        issued == {1'b0, timer_read_word_cmd} |-> mux_output == wordCnt)
        else $error("timer word read wrong");
    timer_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        issued == {1'b0, timer_read_addr_cmd} |-> mux_output == addrCnt)
        else $error("timer address read wrong");
    timer_reload_a: assert property (@(posedge mclk) disable iff (!rst_n)
        issued == {1'b0, timer_reload_both_cmd} |-> mux_output == addrCnt ##1 reloadBothSeq)
        else $error("timer reload wrong");
    timer_load_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        issued == {1'b0, timer_load_addr_cmd} |-> mux_output == wordCnt
        ##1 addrCnt == $past(dataIn) && addrReg == $past(dataIn))
        else $error("timer address load wrong");
    reload_word_a: assert property (@(posedge mclk) disable iff (!rst_n)
        issued == {1'b0, timer_reload_word_cmd} |-> mux_output == wordCnt
        ##1 wordCnt == ($past(opMode) == ModeCompare ? CounterResetValue : $past(wordReg)))
        else $error("word reload wrong");
    mode0_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (opMode == ModeZero && wordCarryLow && wordCnt == CountOne) |-> doneOe == 1'b0)
        else $error("mode 0 done missing");
    mode1_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (opMode == ModeCompare && word_carry_in_n && wordCnt == wordReg) |-> !doneOe)
        else $error("mode 1 done missing");
    mode3_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
        opMode == ModeCarryOut |-> doneOe)
        else $error("done released in mode 3");
    oe_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        dataOe == !data_oe_n)
        else $error("data enable wrong");
    word_carry_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (opMode == ModeCarryOut && !word_carry_in_n && wordCnt == AllOnes) |-> !word_carry_out_n)
        else $error("word carry out missing");
endmodule

/* verification/ctl_model.sv */
// Model of the microprogrammed controller that feeds the slice.
// Assumes the slice samples all its inputs on the rising edge of mclk.
`timescale 1ns/1ps
module ctl_model (
    input wire logic mclk, // Clock
    output logic [3:0] code, // Instruction code
    output logic dis, // Instruction disable
    output logic oeN, // Data output enable, low drives
    output logic [7:0] data, // Data lines toward slice
    output logic wordCarryN, // Word carry in
    output logic addrCarryN // Address carry in
);
    initial begin
        code = 4'h1;
        dis = 1'b0;
        oeN = 1'b1;
        data = 8'h00;
        wordCarryN = 1'b1;
        addrCarryN = 1'b1;
    end
    // One instruction per cycle, changed at the falling edge
    task automatic issue(input logic [3:0] c, input logic [7:0] d, input logic e,
        input logic w, input logic a, input logic o);
        @(negedge mclk);
        code = c;
        dis = e;
        wordCarryN = w;
        addrCarryN = a;
        oeN = o;
        // While the slice drives, the lines show a changing pattern, never a stale value
        data = o ? d : ~data;
    endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench for the DMA address / timer slice.
// Assumes ctl_model drives every slice input except clock and reset.
`timescale 1ns/1ps
module testbench;
    logic mclk;
    logic rst_n;
    logic [3:0] code;
    logic dis, oeN, wordCarryN, addrCarryN;
    logic [7:0] dIn, dOut, muxOut;
    logic dOe, wordCoutN, addrCoutN, doneOut, doneOe;
    int error_cnt = 0;
    int cmp_count = 0;

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    ctl_model ctl (.mclk(mclk), .code(code), .dis(dis), .oeN(oeN), .data(dIn),
        .wordCarryN(wordCarryN), .addrCarryN(addrCarryN));

    dma_address_timer_slice DUT (.mclk(mclk), .rst_n(rst_n), .instruction_code(code),
        .instr_disable(dis), .data_oe_n(oeN), .dataIn(dIn), .dataOut(dOut), .dataOe(dOe),
        .word_carry_in_n(wordCarryN), .word_carry_out_n(wordCoutN),
        .addr_carry_in_n(addrCarryN), .addr_carry_out_n(addrCoutN), .doneOut(doneOut),
        .doneOe(doneOe), .mux_output(muxOut));

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bitchk(input string name, input logic seen, input logic exp);
        chk(name, {7'h00, seen}, {7'h00, exp});
    endtask

    // Instruction with data lines released; mux checked in that cycle
    task automatic op(input logic [3:0] c, input logic [7:0] d, input logic w,
        input logic a, input logic [7:0] exp);
        ctl.issue(c, d, 1'b0, w, a, 1'b1);
        #1;
        chk("mux", muxOut, exp);
        bitchk("dataOe", dOe, 1'b0);
        bitchk("doneOut", doneOut, 1'b0);
    endtask

    // Read with the slice driving the data lines
    task automatic peek(input logic [3:0] c, input logic [7:0] exp);
        ctl.issue(c, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0);
        #1;
        chk("dataOut", dOut, exp);
        bitchk("dataOe", dOe, 1'b1);
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Cuts a hung run short
    initial begin
        repeat (4000) @(posedge mclk);
        error_cnt++;
        complete_run;
    end

    initial begin
        rst_n = 1'b0;
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        peek(4'h1, 8'hF8);
        op(4'h0, 8'h2D, 1'b1, 1'b1, 8'hFF);
        peek(4'h1, 8'hFD);
        op(4'h0, 8'h00, 1'b1, 1'b1, 8'hFF);
        $display("mode register test done");
        op(4'h6, 8'h03, 1'b1, 1'b1, 8'hFF);
        op(4'h5, 8'h10, 1'b1, 1'b1, 8'h03);
        peek(4'h2, 8'h03);
        peek(4'h3, 8'h10);
        op(4'h7, 8'h00, 1'b1, 1'b1, 8'h10);
        op(4'h7, 8'h00, 1'b0, 1'b0, 8'h10);
        op(4'h7, 8'h00, 1'b0, 1'b0, 8'h11);
        op(4'h2, 8'h00, 1'b0, 1'b1, 8'h01);
        bitchk("doneOe", doneOe, 1'b0);
        op(4'h2, 8'h00, 1'b1, 1'b1, 8'h01);
        bitchk("doneOe", doneOe, 1'b1);
        peek(4'h3, 8'h12);
        op(4'h4, 8'h00, 1'b1, 1'b1, 8'h12);
        peek(4'h3, 8'h10);
        peek(4'h2, 8'h03);
        $display("mode zero test done");
        op(4'h0, 8'h01, 1'b1, 1'b1, 8'hFF);
        op(4'h6, 8'h02, 1'b1, 1'b1, 8'hFF);
        peek(4'h2, 8'h00);
        op(4'h7, 8'h00, 1'b0, 1'b1, 8'h10);
        op(4'h2, 8'h00, 1'b0, 1'b1, 8'h01);
        bitchk("doneOe", doneOe, 1'b0);
        op(4'h2, 8'h00, 1'b1, 1'b1, 8'h01);
        bitchk("doneOe", doneOe, 1'b1);
        op(4'h4, 8'h00, 1'b1, 1'b1, 8'h10);
        peek(4'h2, 8'h00);
        $display("mode one test done");
        op(4'h0, 8'h06, 1'b1, 1'b1, 8'hFF);
        op(4'h6, 8'h0E, 1'b1, 1'b1, 8'hFF);
        op(4'h5, 8'h10, 1'b1, 1'b1, 8'h0E);
        op(4'h7, 8'h00, 1'b0, 1'b0, 8'h10);
        op(4'h7, 8'h00, 1'b0, 1'b0, 8'h0F);
        bitchk("doneOe", doneOe, 1'b1);
        peek(4'h2, 8'h0E);
        bitchk("doneOe", doneOe, 1'b0);
        $display("mode two test done");
        op(4'h0, 8'h03, 1'b1, 1'b1, 8'hFF);
        op(4'h6, 8'hFE, 1'b1, 1'b1, 8'hFF);
        op(4'h7, 8'h00, 1'b0, 1'b1, 8'h0E);
        op(4'h2, 8'h00, 1'b0, 1'b1, 8'hFF);
        bitchk("wordCarryOut", wordCoutN, 1'b0);
        bitchk("doneOe", doneOe, 1'b1);
        op(4'h2, 8'h00, 1'b1, 1'b1, 8'hFF);
        bitchk("wordCarryOut", wordCoutN, 1'b1);
        $display("mode three test done");
        ctl.issue(4'h8, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1);
        peek(4'h1, 8'hF8);
        op(4'h6, 8'h05, 1'b1, 1'b1, 8'hFF);
        op(4'h5, 8'h20, 1'b1, 1'b1, 8'h05);
        op(4'hA, 8'h00, 1'b0, 1'b0, 8'h05);
        op(4'hB, 8'h00, 1'b0, 1'b1, 8'h21);
        op(4'h9, 8'h00, 1'b0, 1'b0, 8'h21);
        op(4'hD, 8'h30, 1'b0, 1'b1, 8'h02);
        op(4'hF, 8'h00, 1'b1, 1'b0, 8'h01);
        op(4'hE, 8'h07, 1'b1, 1'b0, 8'hFF);
        op(4'hC, 8'h00, 1'b0, 1'b0, 8'h32);
        ctl.issue(4'hC, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1);
        #1;
        chk("mux", muxOut, 8'h07);
        ctl.issue(4'h4, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1);
        #1;
        chk("mux", muxOut, 8'h31);
        peek(4'h3, 8'h32);
        peek(4'h2, 8'h05);
        op(4'h5, 8'hFF, 1'b1, 1'b1, 8'h05);
        op(4'h3, 8'h00, 1'b1, 1'b0, 8'hFF);
        bitchk("addrCarryOut", addrCoutN, 1'b0);
        op(4'h3, 8'h00, 1'b1, 1'b1, 8'hFF);
        bitchk("addrCarryOut", addrCoutN, 1'b1);
        $display("timer group test done");
        complete_run;
    end
endmodule
